// *** pwrseq_pkg.sv ***
// Shared constants and types for the wireless module power sequencer.
// Assumes a 200 MHz system clock shared by both ends.
package pwrseq_pkg;
  localparam int ClkPeriodNs = 5;
  // Reference clock settle interval and BT wake (RTS fall) upper limit, in ms.
  localparam int RefSettleMs = 55;
  localparam int BtWakeMaxMs = 100;
  // Least enable low time in us.
  localparam int EnableLowUs = 64;
  localparam int NsPerMs = 1000000;
  localparam int NsPerUs = 1000;
  localparam int RefSettleCycles = RefSettleMs * (NsPerMs / ClkPeriodNs);
  localparam int BtWakeMaxCycles = BtWakeMaxMs * (NsPerMs / ClkPeriodNs);
  localparam int EnableLowCycles = (EnableLowUs * NsPerUs + ClkPeriodNs - 1) / ClkPeriodNs;
  // Delay from reference clock valid to the UART completion mark.
  localparam int BtFinishMs = 5;
  localparam int BtFinishCycles = BtFinishMs * (NsPerMs / ClkPeriodNs);
  localparam int CountWidth = 25;
  // Host-side default bring-up length, arbitrary.
  localparam int HostBringupCycles = 16;

  typedef logic [CountWidth-1:0] count_t;
  typedef enum logic [1:0] {CoreOff, CoreSettle, CoreWake, CoreReady} core_state_t;
endpackage

// *** pwrseq_if.sv ***
// Interface joining the host end to the module end.
// Assumes both ends share one clock.
`timescale 1ns/100ps
interface pwrseq_if;
  logic ioSupply;
  logic sleepClockPresent;
  logic batterySupply;
  logic wlanCoreEnable;
  logic btCoreEnable;
  logic uartRtsN;
  logic sdioAttached;

  modport device (
    input ioSupply,
    input sleepClockPresent,
    input batterySupply,
    input wlanCoreEnable,
    input btCoreEnable,
    output uartRtsN,
    input sdioAttached
  );
  modport host (
    output ioSupply,
    output sleepClockPresent,
    output batterySupply,
    output wlanCoreEnable,
    output btCoreEnable,
    input uartRtsN,
    output sdioAttached
  );
endinterface

// *** module_sequencer.sv ***
// Module-side power sequencer: per-core reference clock settle, DC-DC and
// clock request outputs, and the UART completion mark for the BT core.
// Assumes the host keeps its own ordering of supplies and enables.
//
// Operation
// - Host drives no I/O without I/O supply.
// - Wlan_core_enable only after supplies, sleep clock.
// - Reference clock valid 55 ms after Wlan_core_enable.
// - Host bring-up follows reference clock valid.
// - DC-DC request held while any core runs.
// - Clock request held while any core runs.
// - Wlan_core_enable low at least 64 us.
// - Bt_core_enable only after stable supplies.
// - BT reference clock stable within 55 ms.
// - RTS falls within 100 ms of Bt_core_enable.
// - Host interfaces recognised automatically.
`timescale 1ns/100ps
module module_sequencer (
  input wire logic clk,
  input wire logic resetn,
  pwrseq_if.device link,
  output logic dcdcRequest,
  output logic refClockRequest,
  output logic refClockValid,
  output logic wlanBringupReady,
  output logic btInterfaceReady
);
  import pwrseq_pkg::*;

  typedef struct packed {
    core_state_t wlanState;
    core_state_t btState;
    count_t wlanCount;
    count_t btCount;
    logic refValid;
    logic rtsN;
    logic dcdc;
    logic clkReq;
  } seq_t;

  seq_t s_reg, s_next;

  function automatic logic countDone(input count_t c, input int limit);
    countDone = (c >= count_t'(limit - 1));
  endfunction

  always_comb begin
    s_next = s_reg;
    // WLAN core; a drop of its enable powers the core down at once.
    if (!link.wlanCoreEnable) begin
      s_next.wlanState = CoreOff;
      s_next.wlanCount = '0;
    end else begin
      case (s_reg.wlanState)
        CoreOff: begin
          s_next.wlanState = CoreSettle;
          s_next.wlanCount = '0;
        end
        CoreSettle: begin
          s_next.wlanCount = s_reg.wlanCount + count_t'(1);
          if (countDone(s_reg.wlanCount, RefSettleCycles)) begin
            s_next.wlanState = CoreReady;
          end
        end
        CoreWake: s_next.wlanState = CoreReady;
        CoreReady: s_next.wlanState = CoreReady;
        default: s_next.wlanState = CoreOff;
      endcase
    end
    // BT core; the reference clock settles first, then RTS falls.
    if (!link.btCoreEnable) begin
      s_next.btState = CoreOff;
      s_next.btCount = '0;
    end else begin
      case (s_reg.btState)
        CoreOff: begin
          s_next.btState = CoreSettle;
          s_next.btCount = '0;
        end
        CoreSettle: begin
          s_next.btCount = s_reg.btCount + count_t'(1);
          if (countDone(s_reg.btCount, RefSettleCycles)) begin
            s_next.btState = CoreWake;
            s_next.btCount = '0;
          end
        end
        CoreWake: begin
          s_next.btCount = s_reg.btCount + count_t'(1);
          if (countDone(s_reg.btCount, BtFinishCycles)) begin
            s_next.btState = CoreReady;
          end
        end
        CoreReady: s_next.btState = CoreReady;
        default: s_next.btState = CoreOff;
      endcase
    end
    // Requests stay up while either core is enabled, so a WLAN power-down
    // never pulls the shared clock or supply away from a running BT core.
    s_next.dcdc = link.wlanCoreEnable || link.btCoreEnable;
    s_next.clkReq = link.wlanCoreEnable || link.btCoreEnable;
    s_next.refValid = (s_next.wlanState == CoreReady) ||
                      (s_next.btState == CoreWake) || (s_next.btState == CoreReady);
    s_next.rtsN = !(s_next.btState == CoreReady);
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      s_reg <= '{wlanState: CoreOff, btState: CoreOff, wlanCount: '0, btCount: '0,
                 refValid: 1'b0, rtsN: 1'b1, dcdc: 1'b0, clkReq: 1'b0};
    end else begin
      s_reg <= s_next;
    end
  end

  assign dcdcRequest = s_reg.dcdc;
  assign refClockRequest = s_reg.clkReq;
  assign refClockValid = s_reg.refValid;
  assign link.uartRtsN = s_reg.rtsN;
  // Interfaces need no selection step: each core answers on its own port.
  assign wlanBringupReady = (s_reg.wlanState == CoreReady) && link.sdioAttached;
  assign btInterfaceReady = (s_reg.btState == CoreReady);
endmodule

// *** host_sequencer.sv ***
// Host-side power controller: orders supplies, sleep clock and core enables.
// Assumes the module end answers on the shared interface with the same clock.
`timescale 1ns/100ps
module host_sequencer (
  input wire logic clk,
  input wire logic resetn,
  pwrseq_if.host link,
  input wire logic suppliesOn,
  input wire logic wlanRequest,
  input wire logic btRequest,
  output logic wlanEnabled,
  output logic wlanBringupDone,
  output logic btReady,
  output logic btFailed
);
  import pwrseq_pkg::*;

  typedef struct packed {
    logic supplies;
    logic wlanEn;
    logic btEn;
    count_t wlanLowCount;
    count_t wlanUpCount;
    logic wlanDone;
    count_t btWaitCount;
    logic btOk;
    logic btFail;
  } host_t;

  host_t h_reg, h_next;

  always_comb begin
    h_next = h_reg;
    h_next.supplies = suppliesOn;
    // No enable is raised, and no I/O driven, before supplies settle.
    // Looking at the raw input as well drops every enable on the very edge at which
    // the supply lines fall, so no line is ever left high without its supply.
    if (!suppliesOn || !h_reg.supplies) begin
      h_next.wlanEn = 1'b0;
      h_next.btEn = 1'b0;
    end else begin
      // Each core is driven only from its own request.
      if (h_reg.wlanEn) begin
        h_next.wlanEn = wlanRequest;
      end else if (wlanRequest && h_reg.wlanLowCount >= count_t'(EnableLowCycles)) begin
        h_next.wlanEn = 1'b1;
      end
      h_next.btEn = btRequest;
    end
    if (h_reg.wlanEn) begin
      h_next.wlanLowCount = '0;
    end else if (h_reg.wlanLowCount < count_t'(EnableLowCycles)) begin
      h_next.wlanLowCount = h_reg.wlanLowCount + count_t'(1);
    end
    // Host bring-up starts once the settle interval is surely over.
    // Following the next enable keeps the attach line from outliving its enable.
    if (!h_next.wlanEn) begin
      h_next.wlanUpCount = '0;
      h_next.wlanDone = 1'b0;
    end else if (h_reg.wlanUpCount < count_t'(RefSettleCycles + HostBringupCycles)) begin
      h_next.wlanUpCount = h_reg.wlanUpCount + count_t'(1);
    end else begin
      h_next.wlanDone = 1'b1;
    end
    if (!h_reg.btEn) begin
      h_next.btWaitCount = '0;
      h_next.btOk = 1'b0;
      h_next.btFail = 1'b0;
    end else if (!h_reg.btOk && !h_reg.btFail) begin
      h_next.btWaitCount = h_reg.btWaitCount + count_t'(1);
      if (!link.uartRtsN) begin
        h_next.btOk = 1'b1;
      end else if (h_reg.btWaitCount >= count_t'(BtWakeMaxCycles - 1)) begin
        h_next.btFail = 1'b1;
      end
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      h_reg <= '{supplies: 1'b0, wlanEn: 1'b0, btEn: 1'b0,
                 wlanLowCount: count_t'(EnableLowCycles), wlanUpCount: '0,
                 wlanDone: 1'b0, btWaitCount: '0, btOk: 1'b0, btFail: 1'b0};
    end else begin
      h_reg <= h_next;
    end
  end

  assign link.ioSupply = h_reg.supplies;
  assign link.batterySupply = h_reg.supplies;
  assign link.sleepClockPresent = h_reg.supplies;
  assign link.wlanCoreEnable = h_reg.wlanEn;
  assign link.btCoreEnable = h_reg.btEn;
  assign link.sdioAttached = h_reg.wlanDone;
  assign wlanEnabled = h_reg.wlanEn;
  assign wlanBringupDone = h_reg.wlanDone;
  assign btReady = h_reg.btOk;
  assign btFailed = h_reg.btFail;
endmodule

// *** pwrseq_assertions.sv ***
// Checker on the host-to-module power link.
// Assumes one clock; tb instantiates it beside the link.
`timescale 1ns/100ps
module pwrseq_assertions (
  input wire logic clk,
  input wire logic resetn,
  input wire logic ioSupply,
  input wire logic sleepClockPresent,
  input wire logic batterySupply,
  input wire logic wlanCoreEnable,
  input wire logic btCoreEnable,
  input wire logic uartRtsN,
  input wire logic sdioAttached
);
  import pwrseq_pkg::*;
  count_t lowCnt, btCnt, wlCnt;
  logic wasOn;
  // Counters saturate so a long idle never wraps into a short gap.
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      lowCnt <= '0;
      btCnt <= '0;
      wlCnt <= '0;
      wasOn <= 1'b0;
    end else begin
      wasOn <= wasOn | wlanCoreEnable;
      lowCnt <= wlanCoreEnable ? '0 : lowCnt + count_t'(lowCnt < count_t'(EnableLowCycles));
      btCnt <= btCoreEnable ? btCnt + count_t'(btCnt < count_t'(BtWakeMaxCycles)) : '0;
      wlCnt <= wlanCoreEnable ? wlCnt + count_t'(wlCnt < count_t'(RefSettleCycles)) : '0;
    end
  end
  default clocking @(posedge clk); endclocking
  default disable iff (!resetn);
  chk_wlan_supplies: assert property (
    $rose(wlanCoreEnable) |-> batterySupply && ioSupply && sleepClockPresent)
    else $error("wlan_core_enable rose without supplies");
  chk_bt_supplies: assert property (
    $rose(btCoreEnable) |-> ioSupply && sleepClockPresent)
    else $error("bt_core_enable rose without supplies");
  chk_io_first: assert property (
    !ioSupply |-> !wlanCoreEnable && !btCoreEnable && !sdioAttached)
    else $error("line driven without io supply");
  chk_wlan_low_time: assert property (
    $rose(wlanCoreEnable) && wasOn && !btCoreEnable |-> lowCnt >= count_t'(EnableLowCycles))
    else $error("wlan_core_enable low time too short");
  chk_rts_early: assert property (
    $fell(uartRtsN) |-> btCnt >= count_t'(RefSettleCycles))
    else $error("rts fell before clock settle");
  chk_rts_late: assert property (
    btCnt == count_t'(BtWakeMaxCycles) |-> !uartRtsN)
    else $error("rts not low within wake limit");
  chk_rts_release: assert property (
    $fell(btCoreEnable) |-> ##[1:2] uartRtsN)
    else $error("rts not released after bt off");
  chk_sdio_after: assert property (
    $rose(sdioAttached) |-> wlanCoreEnable && wlCnt >= count_t'(RefSettleCycles))
    else $error("host bring-up before clock valid");
endmodule

// *** tb.sv ***
// Bench joining host and module ends over the link.
// Assumes package counts; only early power-up phases fit the run.
`timescale 1ns/100ps
module tb;
  import pwrseq_pkg::*;
  logic clk, resetn, suppliesOn, wlanRequest, btRequest;
  logic dcdcRequest, refClockRequest, refClockValid, wlanBringupReady, btInterfaceReady;
  logic wlanEnabled, wlanBringupDone, btReady, btFailed;
  logic [31:0] lfsr;
  int nFail, compares, n, lowCycles;
  int mSup, mWlan, mBt, mLow, nWlan;
  int reqLine[$];
  logic [4:0] seenBits, expBits;
  pwrseq_if link();
  module_sequencer module_sequencer_inst(.clk(clk), .resetn(resetn), .link(link),
    .dcdcRequest(dcdcRequest), .refClockRequest(refClockRequest),
    .refClockValid(refClockValid), .wlanBringupReady(wlanBringupReady),
    .btInterfaceReady(btInterfaceReady));
  host_sequencer host_sequencer_inst(.clk(clk), .resetn(resetn), .link(link),
    .suppliesOn(suppliesOn), .wlanRequest(wlanRequest), .btRequest(btRequest),
    .wlanEnabled(wlanEnabled), .wlanBringupDone(wlanBringupDone), .btReady(btReady),
    .btFailed(btFailed));
  pwrseq_assertions pwrseq_assertions_inst(.clk(clk), .resetn(resetn),
    .ioSupply(link.ioSupply), .sleepClockPresent(link.sleepClockPresent),
    .batterySupply(link.batterySupply), .wlanCoreEnable(link.wlanCoreEnable),
    .btCoreEnable(link.btCoreEnable), .uartRtsN(link.uartRtsN),
    .sdioAttached(link.sdioAttached));
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      nFail++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  function automatic logic [31:0] lfsrNext(input logic [31:0] v);
    lfsrNext = {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction
  task automatic close_out();
    $display("compares=%0d mismatches=%0d", compares, nFail);
    if (nFail == 0 && compares > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  // Bounded so a stuck enable ends in a mismatch, not a hang.
  task automatic waitWlan(input logic lvl, output int cnt);
    cnt = 0;
    while (link.wlanCoreEnable !== lvl && cnt < 20000) begin
      @(posedge clk);
      cnt++;
    end
    check(link.wlanCoreEnable, lvl);
  endtask
  // Reference model of the host rules and the request outputs. At each edge it
  // checks the levels left by the previous edge, then steps on this edge's inputs.
  always @(posedge clk) begin
    if (!resetn) begin
      mSup = 0;
      mWlan = 0;
      mBt = 0;
      mLow = EnableLowCycles;
      reqLine = {0};
    end else begin
      seenBits = {link.ioSupply, link.wlanCoreEnable, link.btCoreEnable, dcdcRequest,
                  refClockRequest};
      expBits = {mSup != 0, mWlan != 0, mBt != 0, reqLine[0] != 0, reqLine[0] != 0};
      check(seenBits, expBits);
      reqLine.push_back(mWlan | mBt);
      void'(reqLine.pop_front());
      nWlan = mWlan;
      if (!suppliesOn || mSup == 0) begin
        nWlan = 0;
        mBt = 0;
      end else begin
        if (mWlan != 0) begin
          nWlan = int'(wlanRequest);
        end else if (wlanRequest && mLow >= EnableLowCycles) begin
          nWlan = 1;
        end
        mBt = int'(btRequest);
      end
      mLow = (mWlan != 0) ? 0 : ((mLow < EnableLowCycles) ? mLow + 1 : mLow);
      mWlan = nWlan;
      mSup = int'(suppliesOn);
    end
  end
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  initial begin
    repeat (60000) @(posedge clk);
    nFail++;
    close_out();
  end
  initial begin
    resetn = 1'b0;
    suppliesOn = 1'b0;
    wlanRequest = 1'b0;
    btRequest = 1'b0;
    lfsr = 32'hf21b;
    repeat (4) @(posedge clk);
    resetn <= 1'b1;
    repeat (2) @(posedge clk);
    check({dcdcRequest, refClockRequest, link.wlanCoreEnable, link.uartRtsN}, 4'h1);
    wlanRequest <= 1'b1;
    repeat (10) @(posedge clk);
    check(link.wlanCoreEnable, 1'b0);
    suppliesOn <= 1'b1;
    repeat (5) @(posedge clk);
    check({link.wlanCoreEnable, dcdcRequest, refClockRequest}, 3'h7);
    $display("test order done");
    for (int i = 0; i < 40; i++) begin
      lfsr = lfsrNext(lfsr);
      btRequest <= lfsr[0];
      repeat (5) @(posedge clk);
      check({link.wlanCoreEnable, link.btCoreEnable}, {1'b1, lfsr[0]});
      check({refClockValid, link.uartRtsN, btInterfaceReady, btReady}, 4'h4);
    end
    $display("test independence done");
    btRequest <= 1'b1;
    wlanRequest <= 1'b0;
    repeat (5) @(posedge clk);
    check({link.wlanCoreEnable, dcdcRequest, refClockRequest}, 3'h3);
    btRequest <= 1'b0;
    repeat (5) @(posedge clk);
    check({dcdcRequest, refClockRequest, link.uartRtsN}, 3'h1);
    $display("test shared requests done");
    wlanRequest <= 1'b1;
    waitWlan(1'b1, n);
    wlanRequest <= 1'b0;
    waitWlan(1'b0, n);
    wlanRequest <= 1'b1;
    waitWlan(1'b1, lowCycles);
    check(lowCycles >= EnableLowCycles - 2 && lowCycles <= EnableLowCycles + 4, 1'b1);
    check({wlanBringupReady, wlanBringupDone, btFailed}, 3'h0);
    $display("test low time done");
    suppliesOn <= 1'b0;
    repeat (3) @(posedge clk);
    check({link.ioSupply, wlanEnabled, link.btCoreEnable, link.sdioAttached}, 4'h0);
    $display("test supply drop done");
    close_out();
  end
endmodule
